/* hw/dss_pkg.sv */
// Function
// R1 - 22-bit shift register: 20 data, 2 address
// R2 - Load strobe rise copies data to word
// R3 - Host shifts MSB first, address last
// R4 - Address selects b-ref, b-fb, a-ref, a-fb
// R5 - Reference word field layout
// R6 - Fast-acquisition mode enables open-drain pulldown
// R7 - Host picks high pump current for acquisition
// R8 - Reset-b mode holds synth_b dividers
// R9 - Reset-a mode holds synth_a dividers
// R10 - Reset-all mode holds every divider
// R11 - Held dividers release together
// R12 - Output can monitor any divider
// R13 - Powerdown disables prescaler, detector, pump, pins
// R14 - Powered-down dividers frozen at load value
// R15 - Both down: osc buffer off, pulled high
// R16 - Power-up holds dividers for settling delay
// R17 - Serial loading works during powerdown
// R18 - Synchronous powerdown waits for pump pulse end
// R19 - Asynchronous powerdown enters at once
// R20 - {pump_hiz, power_off_bit} selects operating mode
// R21 - Serial data sampled on serial clock rise
// R22 - Feedback word field layout
// R23 - Reference divider 15-bit, ratio 3..32767
// R24 - Powerdown drives multi-function output low
// R25 - Four select bits form one mode code
package dss_pkg;

    // ----------------------------------------------------------------
    // Serial word layout
    // ----------------------------------------------------------------
    localparam int SHIFT_W  = 22;
    localparam int DATA_W   = 20;
    localparam int ADDR_W   = 2;
    localparam int DATA_LSB = 2;

    // Word addresses
    localparam logic [1:0] ADR_B_REF = 2'h0;
    localparam logic [1:0] ADR_B_FB  = 2'h1;
    localparam logic [1:0] ADR_A_REF = 2'h2;
    localparam logic [1:0] ADR_A_FB  = 2'h3;

    // Synthesizer index inside vectors
    localparam int SYN_B = 0;
    localparam int SYN_A = 1;

    // Reference word fields, positions inside the data field
    localparam int RF_MF_HI   = 19;
    localparam int RF_MF_LO   = 18;
    localparam int RF_HIZ     = 17;
    localparam int RF_CUR     = 16;
    localparam int RF_POL     = 15;
    localparam int RF_DIV_MSB = 14;
    localparam int RF_DIV_LSB = 0;
    localparam int REF_W      = 15;

    // Feedback word fields, positions inside the data field
    localparam int FB_PWR   = 19;
    localparam int FB_PRE   = 18;
    localparam int FB_B_MSB = 17;
    localparam int FB_B_LSB = 7;
    localparam int FB_A_MSB = 6;
    localparam int FB_A_LSB = 0;
    localparam int B_W      = 11;
    localparam int A_W      = 7;

    localparam logic [DATA_W-1:0] CTL_RESET = 20'h0_0000;

    // ----------------------------------------------------------------
    // Multi-function select codes
    // ----------------------------------------------------------------
    localparam logic [3:0] MF_LOW     = 4'h0;
    localparam logic [3:0] MF_LD_A    = 4'h1;
    localparam logic [3:0] MF_LD_B    = 4'h2;
    localparam logic [3:0] MF_LD_BOTH = 4'h3;
    localparam logic [3:0] MF_MON_RA  = 4'h4;
    localparam logic [3:0] MF_MON_RB  = 4'h5;
    localparam logic [3:0] MF_MON_FA  = 4'h6;
    localparam logic [3:0] MF_MON_FB  = 4'h7;
    localparam logic [3:0] MF_FASTACQ = 4'h8;
    localparam logic [3:0] MF_RST_A   = 4'h9;
    localparam logic [3:0] MF_RST_B   = 4'hA;
    localparam logic [3:0] MF_RST_ALL = 4'hB;
    localparam logic [3:0] MF_HIGH    = 4'hC;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_NS     = 50;
    localparam int SETTLE_NS  = 1000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W      = 8;
    localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYC);

    // Per-synthesizer power state
    typedef enum logic [2:0] {
        PWR_ACTIVE,
        PWR_ARM,
        PWR_DRAIN,
        PWR_OFF,
        PWR_SETTLE
    } dss_pwr_e;

endpackage : dss_pkg

/* hw/dss_div_if.sv */
// Control and terminal-count signals between the top and one divider
interface dss_div_if #(parameter int W = 15);
    logic         hold;
    logic         tick;
    logic [W-1:0] load;
    logic         term;

    modport ctrl (output hold, output tick, output load, input term);
    modport div  (input hold, input tick, input load, output term);
endinterface : dss_div_if

/* hw/dss_div.sv */
// Down-counting divider; one terminal pulse per load ticks
module dss_div
    import dss_pkg::*;
#(
    parameter int W = 15
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control side
    dss_div_if.div   bus
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         term;
    } dss_div_s;

    dss_div_s div_r;
    dss_div_s div_nxt;

    // Hold parks the count at the load value until release
    always_comb begin
        div_nxt      = div_r;
        div_nxt.term = 1'b0;
        if (bus.hold) begin
            div_nxt.cnt = bus.load; // R14
        end else if (bus.tick) begin
            if (div_r.cnt <= W'(1)) begin
                div_nxt.cnt  = bus.load; // R23
                div_nxt.term = 1'b1;
            end else begin
                div_nxt.cnt = div_r.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    assign bus.term = div_r.term;

endmodule : dss_div

/* hw/dss_top.sv */
// Serial load port, control words, power and output control of both synths
module dss_top
    import dss_pkg::*;
(
    // Clocks and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       ser_clk,
    // Serial load port
    input  wire logic       ser_data,
    input  wire logic       load_strobe,
    // Divider timing inputs
    input  wire logic       ref_osc_input,
    input  wire logic [1:0] prescaler_out,
    // Per-synthesizer outputs, index 1 is synth_a
    output logic      [1:0] prescaler_en,
    output logic      [1:0] prescaler_sel,
    output logic      [1:0] modulus_sel,
    output logic      [1:0] pump_up,
    output logic      [1:0] pump_down,
    output logic      [1:0] pump_oe,
    output logic      [1:0] pump_current_sel,
    output logic      [1:0] fb_in_hiz,
    // Oscillator buffer control
    output logic            osc_buf_en,
    output logic            osc_pullup_en,
    // Multi-function pin
    output logic            multi_function_out,
    output logic            mf_od_en
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [SHIFT_W-1:0] shift;
    } dss_ser_s;

    typedef struct packed {
        logic                        ls_s1;
        logic                        ls_s2;
        logic                        ls_d;
        logic                        osc_s1;
        logic                        osc_s2;
        logic                        osc_d;
        logic [1:0]                  pre_s1;
        logic [1:0]                  pre_s2;
        logic [1:0]                  pre_d;
        logic [3:0][DATA_W-1:0]      ctl;
        dss_pwr_e [1:0]              pwr;
        logic [1:0][CNT_W-1:0]       wait_cnt;
        logic [1:0][A_W-1:0]         sw_cnt;
        logic [1:0]                  up;
        logic [1:0]                  dn;
        logic [1:0]                  pre_en;
        logic [1:0]                  pre_sel;
        logic [1:0]                  mod_sel;
        logic [1:0]                  pu;
        logic [1:0]                  pdn;
        logic [1:0]                  pump_oe;
        logic [1:0]                  cur;
        logic [1:0]                  fb_hiz;
        logic                        osc_en;
        logic                        osc_pull;
        logic                        mf_o;
        logic                        mf_od;
    } dss_state_s;

    dss_ser_s   ser_r;
    dss_ser_s   ser_nxt;
    dss_state_s st_r;
    dss_state_s st_nxt;

    // Combinational helpers
    logic [1:0][DATA_W-1:0] ref_w;
    logic [1:0][DATA_W-1:0] fb_w;
    logic [1:0]             hold_w;
    logic [1:0]             rst_mode;
    logic [1:0]             pre_tick;
    logic [1:0]             lock;
    logic [1:0]             up_n;
    logic [1:0]             dn_n;
    logic [1:0]             ref_term;
    logic [1:0]             fb_term;
    logic [1:0][REF_W-1:0]  ref_load;
    logic [1:0][B_W-1:0]    fb_load;
    logic [3:0]             mf_code;
    logic                   osc_tick;
    logic                   ls_rise;
    logic                   any_off;

    // ----------------------------------------------------------------
    // Serial side, on the link clock
    // ----------------------------------------------------------------

    // MSB arrives first, so the address ends up in the low bits
    always_comb begin
        ser_nxt.shift = {ser_r.shift[SHIFT_W-2:0], ser_data}; // R1 R3
    end

    // Keeps shifting whatever the power state is
    always_ff @(posedge ser_clk or posedge rst) begin // R21 R17
        if (rst) begin
            ser_r <= '0;
        end else begin
            ser_r <= ser_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Dividers, two per synthesizer
    // ----------------------------------------------------------------
    for (genvar s = 0; s < 2; s++) begin : g_syn
        dss_div_if #(.W(REF_W)) ref_if ();
        dss_div_if #(.W(B_W))   fb_if  ();

        // Same hold term on both, so they restart on one edge
        assign ref_if.hold = hold_w[s]; // R11
        assign fb_if.hold  = hold_w[s]; // R11
        assign ref_if.tick = osc_tick;
        assign fb_if.tick  = pre_tick[s];
        assign ref_if.load = ref_load[s];
        assign fb_if.load  = fb_load[s];
        assign ref_term[s] = ref_if.term;
        assign fb_term[s]  = fb_if.term;

        dss_div #(.W(REF_W)) u_ref (
            .clk (sys_clk),
            .rst (rst),
            .bus (ref_if)
        );

        dss_div #(.W(B_W)) u_fb (
            .clk (sys_clk),
            .rst (rst),
            .bus (fb_if)
        );
    end

    // ----------------------------------------------------------------
    // Control logic, on the system clock
    // ----------------------------------------------------------------

    // Next-state function for everything on the system clock
    always_comb begin
        st_nxt = st_r;

        // Two-stage synchronisers; edges come from stage two and its delayed copy
        st_nxt.ls_s1  = load_strobe;
        st_nxt.ls_s2  = st_r.ls_s1;
        st_nxt.ls_d   = st_r.ls_s2;
        st_nxt.osc_s1 = ref_osc_input;
        st_nxt.osc_s2 = st_r.osc_s1;
        st_nxt.osc_d  = st_r.osc_s2;
        st_nxt.pre_s1 = prescaler_out;
        st_nxt.pre_s2 = st_r.pre_s1;
        st_nxt.pre_d  = st_r.pre_s2;

        // Edge events; a disabled buffer or prescaler gives no ticks
        ls_rise  = st_r.ls_s2 & ~st_r.ls_d;
        osc_tick = st_r.osc_s2 & ~st_r.osc_d & st_r.osc_en;
        pre_tick = st_r.pre_s2 & ~st_r.pre_d & st_r.pre_en;

        // Shift register is quiet while the strobe is high, so the
        // synchronised strobe edge is the handshake for the word
        if (ls_rise) begin
            st_nxt.ctl[ser_r.shift[ADDR_W-1:0]] =
                ser_r.shift[SHIFT_W-1:DATA_LSB]; // R2 R4
        end

        // Word views per synthesizer
        ref_w[SYN_B] = st_r.ctl[ADR_B_REF];
        fb_w[SYN_B]  = st_r.ctl[ADR_B_FB];
        ref_w[SYN_A] = st_r.ctl[ADR_A_REF];
        fb_w[SYN_A]  = st_r.ctl[ADR_A_FB];

        // Select bits from both reference words form one code
        mf_code = {ref_w[SYN_A][RF_MF_LO], ref_w[SYN_B][RF_MF_LO],
                   ref_w[SYN_A][RF_MF_HI], ref_w[SYN_B][RF_MF_HI]}; // R25 R5

        // Counter-reset modes
        rst_mode[SYN_B] = (mf_code == MF_RST_B)
                        || (mf_code == MF_RST_ALL); // R8 R10
        rst_mode[SYN_A] = (mf_code == MF_RST_A)
                        || (mf_code == MF_RST_ALL); // R9 R10

        for (int s = 0; s < 2; s++) begin
            ref_load[s] = ref_w[s][RF_DIV_MSB:RF_DIV_LSB]; // R5 R23
            fb_load[s]  = fb_w[s][FB_B_MSB:FB_B_LSB]; // R22
            lock[s]     = ~(st_r.up[s] | st_r.dn[s]);

            // Dividers stay parked while off, settling or reset
            hold_w[s] = rst_mode[s]
                      || (st_r.pwr[s] == PWR_OFF)
                      || (st_r.pwr[s] == PWR_SETTLE); // R14 R16

            // Power state per {pump_hiz, power_off_bit}
            unique case (st_r.pwr[s])
                PWR_ACTIVE: begin
                    if (fb_w[s][FB_PWR]) begin
                        if (ref_w[s][RF_HIZ]) begin
                            st_nxt.pwr[s] = PWR_OFF; // R19 R20
                        end else if (!lock[s]) begin
                            st_nxt.pwr[s] = PWR_DRAIN; // R18
                        end else begin
                            st_nxt.pwr[s] = PWR_ARM; // R18 R20
                        end
                    end
                end
                PWR_ARM: begin
                    if (!fb_w[s][FB_PWR]) begin
                        st_nxt.pwr[s] = PWR_ACTIVE;
                    end else if (ref_w[s][RF_HIZ]) begin
                        st_nxt.pwr[s] = PWR_OFF; // R19
                    end else if (!lock[s]) begin
                        st_nxt.pwr[s] = PWR_DRAIN; // R18
                    end
                end
                PWR_DRAIN: begin
                    if (!fb_w[s][FB_PWR]) begin
                        st_nxt.pwr[s] = PWR_ACTIVE;
                    end else if (ref_w[s][RF_HIZ] || lock[s]) begin
                        st_nxt.pwr[s] = PWR_OFF; // R18 R19
                    end
                end
                PWR_OFF: begin
                    if (!fb_w[s][FB_PWR]) begin
                        st_nxt.pwr[s]      = PWR_SETTLE; // R16
                        st_nxt.wait_cnt[s] = SETTLE_LOAD;
                    end
                end
                PWR_SETTLE: begin
                    if (fb_w[s][FB_PWR]) begin
                        st_nxt.pwr[s] = PWR_OFF;
                    end else if (st_r.wait_cnt[s] <= CNT_W'(1)) begin
                        st_nxt.pwr[s] = PWR_ACTIVE; // R16
                    end else begin
                        st_nxt.wait_cnt[s] = st_r.wait_cnt[s] - 1'b1;
                    end
                end
                default: begin
                    st_nxt.pwr[s] = PWR_OFF;
                end
            endcase

            // Phase detector: reference edge pumps up, feedback down;
            // once both have fired the pulse ends
            up_n[s] = st_r.up[s] | ref_term[s];
            dn_n[s] = st_r.dn[s] | fb_term[s];
            if (hold_w[s] || (up_n[s] && dn_n[s])) begin // R13
                up_n[s] = 1'b0;
                dn_n[s] = 1'b0;
            end
            st_nxt.up[s] = up_n[s];
            st_nxt.dn[s] = dn_n[s];

            // Polarity swaps pump direction for negative tuning slope
            st_nxt.pu[s]  = ref_w[s][RF_POL] ? up_n[s] : dn_n[s]; // R5
            st_nxt.pdn[s] = ref_w[s][RF_POL] ? dn_n[s] : up_n[s];

            // Swallow counter: prescaler runs at P+1 while it is nonzero
            if (hold_w[s] || fb_term[s]) begin
                st_nxt.sw_cnt[s] = fb_w[s][FB_A_MSB:FB_A_LSB]; // R22
            end else if (pre_tick[s] && (st_r.sw_cnt[s] != '0)) begin
                st_nxt.sw_cnt[s] = st_r.sw_cnt[s] - 1'b1;
            end
            st_nxt.mod_sel[s] = (st_nxt.sw_cnt[s] != '0);

            // Power pin controls follow the next power state; selects follow the words
            st_nxt.pre_en[s]  = (st_nxt.pwr[s] != PWR_OFF); // R13
            st_nxt.fb_hiz[s]  = (st_nxt.pwr[s] == PWR_OFF); // R13
            st_nxt.pump_oe[s] = !ref_w[s][RF_HIZ]
                              && (st_nxt.pwr[s] != PWR_OFF); // R13 R20
            st_nxt.pre_sel[s] = fb_w[s][FB_PRE]; // R22
            st_nxt.cur[s]     = ref_w[s][RF_CUR]; // R5
        end

        // Buffer only stops when nothing needs the reference
        st_nxt.osc_en   = !((st_nxt.pwr[SYN_A] == PWR_OFF)
                         && (st_nxt.pwr[SYN_B] == PWR_OFF)); // R15
        st_nxt.osc_pull = !st_nxt.osc_en; // R15

        // Multi-function pin
        any_off = (st_r.pwr[SYN_A] == PWR_OFF)
               || (st_r.pwr[SYN_B] == PWR_OFF);
        st_nxt.mf_o  = 1'b0;
        st_nxt.mf_od = 1'b0;
        if (!any_off) begin // R24
            case (mf_code)
                MF_LD_A: begin
                    st_nxt.mf_o = lock[SYN_A];
                end
                MF_LD_B: begin
                    st_nxt.mf_o = lock[SYN_B];
                end
                MF_LD_BOTH: begin
                    st_nxt.mf_o = lock[SYN_A] & lock[SYN_B];
                end
                MF_MON_RA: begin
                    st_nxt.mf_o = ref_term[SYN_A]; // R12
                end
                MF_MON_RB: begin
                    st_nxt.mf_o = ref_term[SYN_B]; // R12
                end
                MF_MON_FA: begin
                    st_nxt.mf_o = fb_term[SYN_A]; // R12
                end
                MF_MON_FB: begin
                    st_nxt.mf_o = fb_term[SYN_B]; // R12
                end
                MF_FASTACQ: begin
                    st_nxt.mf_od = 1'b1; // R6
                end
                MF_HIGH: begin
                    st_nxt.mf_o = 1'b1;
                end
                default: begin
                    st_nxt.mf_o = 1'b0;
                end
            endcase
        end
    end

    // Single register stage for the system-clock state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r          <= '0;
            st_r.ctl      <= {4{CTL_RESET}};
            st_r.pwr      <= '{PWR_ACTIVE, PWR_ACTIVE};
            st_r.osc_en   <= 1'b1;
            st_r.pre_en   <= 2'h3;
            st_r.pump_oe  <= 2'h3;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ----------------------------------------------------------------
    assign prescaler_en       = st_r.pre_en;
    assign prescaler_sel      = st_r.pre_sel;
    assign modulus_sel        = st_r.mod_sel;
    assign pump_up            = st_r.pu;
    assign pump_down          = st_r.pdn;
    assign pump_oe            = st_r.pump_oe;
    assign pump_current_sel   = st_r.cur;
    assign fb_in_hiz          = st_r.fb_hiz;
    assign osc_buf_en         = st_r.osc_en;
    assign osc_pullup_en      = st_r.osc_pull;
    assign multi_function_out = st_r.mf_o;
    assign mf_od_en           = st_r.mf_od;

endmodule : dss_top

/* sim/dss_top_monitor.sv */
module dss_top_monitor (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    // Observed pins
    input wire logic       load_strobe,
    input wire logic [1:0] prescaler_en,
    input wire logic [1:0] prescaler_sel,
    input wire logic [1:0] pump_up,
    input wire logic [1:0] pump_down,
    input wire logic [1:0] pump_oe,
    input wire logic [1:0] pump_current_sel,
    input wire logic [1:0] fb_in_hiz,
    input wire logic       osc_buf_en,
    input wire logic       osc_pullup_en,
    input wire logic       multi_function_out
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // ------
    // Power state at the pins
    // ------
    property p_off_pins;
        fb_in_hiz[1] |-> !prescaler_en[1] && !pump_oe[1];
    endproperty
    a_off_pins: assert property (p_off_pins) else $error("synth_a off, pins live");

    property p_off_entry;
        $fell(prescaler_en[0]) |-> fb_in_hiz[0] && !pump_oe[0];
    endproperty
    a_off_entry: assert property (p_off_entry) else $error("synth_b entry bad");

    // Two cycles in, any pulse from before must be gone
    property p_pump_quiet;
        fb_in_hiz[0] [*2] |-> !pump_up[0] && !pump_down[0];
    endproperty
    a_pump_quiet: assert property (p_pump_quiet) else $error("pump busy while off");

    property p_osc_off;
        osc_pullup_en |-> !osc_buf_en && (&fb_in_hiz);
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("osc pulled up too early");

    property p_osc_on;
        !(&fb_in_hiz) |-> osc_buf_en && !osc_pullup_en;
    endproperty
    a_osc_on: assert property (p_osc_on) else $error("osc buffer off too early");

    // ------
    // Multi-function pin and loading
    // ------
    sequence s_held_off;
        (|fb_in_hiz) ##1 (|fb_in_hiz);
    endsequence
    property p_mf_low;
        s_held_off |-> !multi_function_out;
    endproperty
    a_mf_low: assert property (p_mf_low) else $error("mf pin high in powerdown");

    // Word outputs move only a fixed distance behind a strobe
    property p_load_cause;
        $changed({pump_current_sel, prescaler_sel}) |-> $past(load_strobe, 3);
    endproperty
    a_load_cause: assert property (p_load_cause) else $error("word change w/o strobe");

    property p_wake;
        $fell(fb_in_hiz[1]) |-> prescaler_en[1] && osc_buf_en;
    endproperty
    a_wake: assert property (p_wake) else $error("synth_a wake unpowered");
endmodule : dss_top_monitor

bind dss_top dss_top_monitor u_mon (
    .sys_clk(sys_clk), .rst(rst), .load_strobe(load_strobe),
    .prescaler_en(prescaler_en), .prescaler_sel(prescaler_sel),
    .pump_up(pump_up), .pump_down(pump_down), .pump_oe(pump_oe),
    .pump_current_sel(pump_current_sel), .fb_in_hiz(fb_in_hiz),
    .osc_buf_en(osc_buf_en), .osc_pullup_en(osc_pullup_en),
    .multi_function_out(multi_function_out)
);

/* sim/dss_host_model.sv */
module dss_host_model (
    // Serial load port
    output logic ser_clk,
    output logic ser_data,
    output logic load_strobe
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle: clock parked low, strobe low
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        load_strobe = 1'b0;
    end

    // One word, MSB first; the clock stands still between words
    task automatic send(input logic [21:0] w);
        for (int i = 21; i >= 0; i--) begin
            ser_data = w[i];
            #62.5 ser_clk = 1'b1;
            #62.5 ser_clk = 1'b0;
        end
        // Released line shows the inverse so a stale bit never passes
        ser_data = ~w[0];
        #37 load_strobe = 1'b1;
        #400 load_strobe = 1'b0;
        #200;
    endtask : send
endmodule : dss_host_model

/* sim/tb_dual_synth_serial_control.sv */
module tb_dual_synth_serial_control import dss_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic       ser_clk, ser_data, load_strobe;
    logic       ref_osc_input = 1'b0;
    logic [1:0] prescaler_out = 2'h0;
    logic [1:0] prescaler_en, prescaler_sel, modulus_sel, pump_up, pump_down;
    logic [1:0] pump_oe, pump_current_sel, fb_in_hiz;
    logic       osc_buf_en, osc_pullup_en, multi_function_out, mf_od_en;
    logic       run = 1'b0;
    int         n_fail = 0;
    int         n_compared = 0;
    int         mf_n, act_a, act_b;
    // Mode table: active synths, select code, expected mf pulses (ff: none)
    logic [13:0] tbl [8] = '{{2'h3, MF_MON_RA, 8'h64}, {2'h3, MF_MON_RB, 8'h64},
        {2'h3, MF_MON_FA, 8'h4b}, {2'h3, MF_MON_FB, 8'h4b}, {2'h1, MF_RST_A, 8'hff},
        {2'h2, MF_RST_B, 8'hff}, {2'h0, MF_RST_ALL, 8'hff}, {2'h3, MF_LOW, 8'hff}};

    dss_host_model host (.ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe));

    dss_top dut (
        .sys_clk(sys_clk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data),
        .load_strobe(load_strobe), .ref_osc_input(ref_osc_input),
        .prescaler_out(prescaler_out), .prescaler_en(prescaler_en),
        .prescaler_sel(prescaler_sel), .modulus_sel(modulus_sel), .pump_up(pump_up),
        .pump_down(pump_down), .pump_oe(pump_oe), .pump_current_sel(pump_current_sel),
        .fb_in_hiz(fb_in_hiz), .osc_buf_en(osc_buf_en), .osc_pullup_en(osc_pullup_en),
        .multi_function_out(multi_function_out), .mf_od_en(mf_od_en)
    );

    // Clock
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // Divider ticks: a rising edge every second cycle, slow enough for the sync
    always @(negedge sys_clk) begin
        if (run) begin
            ref_osc_input <= ~ref_osc_input;
            prescaler_out <= ~prescaler_out;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wt

    // Both reference words; ratio 3 is the smallest legal one
    task automatic mode(input logic [3:0] c, input logic [1:0] hiz, input logic [1:0] cur);
        host.send({c[1], c[3], hiz[1], cur[1], 1'b1, 15'h3, ADR_A_REF});
        host.send({c[0], c[2], hiz[0], cur[0], 1'b1, 15'h3, ADR_B_REF});
        wt(4);
    endtask : mode

    task automatic fb(input logic [1:0] adr, input logic pwr, input logic pre);
        host.send({pwr, pre, 11'h4, 7'h0, adr});
        wt(4);
    endtask : fb

    // Counts mf rises and cycles with pump activity per synth
    task automatic watch(input int n);
        logic prev;
        mf_n = 0;
        act_a = 0;
        act_b = 0;
        prev = multi_function_out;
        repeat (n) begin
            @(negedge sys_clk);
            if (multi_function_out && !prev) mf_n++;
            prev = multi_function_out;
            if (pump_up[1] || pump_down[1]) act_a++;
            if (pump_up[0] || pump_down[0]) act_b++;
        end
    endtask : watch

    task automatic end_of_test;
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    // Watchdog, well beyond the expected run of about 0.37 ms
    initial begin
        #2ms;
        n_fail++;
        $display("Watchdog expired");
        end_of_test();
    end

    initial begin
        int e;
        wt(8);
        rst = 1'b0;
        wt(2);
        chk({prescaler_en, pump_oe, fb_in_hiz, osc_buf_en, osc_pullup_en,
             multi_function_out, mf_od_en, pump_current_sel}, 32'h0000_0f20);
        $display("Test reset done");
        fb(ADR_A_FB, 1'b0, 1'b1);
        chk(prescaler_sel, 32'h0000_0002);
        fb(ADR_B_FB, 1'b0, 1'b1);
        chk(prescaler_sel, 32'h0000_0003);
        mode(MF_LOW, 2'h0, 2'h1);
        chk(pump_current_sel, 32'h0000_0001);
        mode(MF_FASTACQ, 2'h1, 2'h2);
        chk({mf_od_en, pump_oe, pump_current_sel}, 32'h0000_001a);
        $display("Test decode done");
        run = 1'b1;
        foreach (tbl[i]) begin
            mode(tbl[i][11:8], 2'h0, 2'h0);
            wt(20);
            watch(600);
            e = tbl[i][7:0];
            if (e != 255) chk(mf_n >= e - 1 && mf_n <= e + 1, 1);
            chk({act_a > 0, act_b > 0}, tbl[i][13:12]);
        end
        $display("Test modes done");
        mode(MF_HIGH, 2'h0, 2'h0);
        chk(multi_function_out, 1'h1);
        run = 1'b0;
        fb(ADR_A_FB, 1'b1, 1'b1);
        wt(40);
        chk(fb_in_hiz, 32'h0000_0000);
        run = 1'b1;
        wt(60);
        run = 1'b0;
        chk({prescaler_en, pump_oe, fb_in_hiz, multi_function_out}, 32'h0000_002c);
        mode(MF_HIGH, 2'h1, 2'h2);
        chk({pump_oe, pump_current_sel}, 32'h0000_0002);
        fb(ADR_B_FB, 1'b1, 1'b1);
        chk({fb_in_hiz, osc_buf_en, osc_pullup_en}, 32'h0000_000d);
        run = 1'b1;
        host.send({1'b0, 1'b1, 11'h4, 7'h2, ADR_A_FB});
        watch(8);
        chk({fb_in_hiz, osc_buf_en, osc_pullup_en, act_a > 0}, 32'h0000_000c);
        chk(modulus_sel, 32'h0000_0002);
        watch(200);
        chk(act_a > 0, 1'h1);
        $display("Test power done");
        end_of_test();
    end
endmodule : tb_dual_synth_serial_control
